// ===== rtl/aalfo_defs.svh
`ifndef AALFO_DEFS_SVH
`define AALFO_DEFS_SVH
// Bus register byte offsets
`define AALFO_OFS_INSTR 8'h00
`define AALFO_OFS_ACC 8'h04
`define AALFO_OFS_FLAGS 8'h08
`define AALFO_OFS_CTRL 8'h0C
`define AALFO_OFS_TIMER 8'h10
`define AALFO_OFS_FADDR 8'h14
`define AALFO_OFS_FDATA 8'h18
// Flag and control register fields
`define AALFO_FLG_CARRY 0
`define AALFO_FLG_DIGIT 1
`define AALFO_FLG_ZERO 2
`define AALFO_FLG_BUSY 8
`define AALFO_CTRL_PSA 0
// Instruction fields
`define AALFO_OPC_HI 13
`define AALFO_OPC_LO 8
`define AALFO_DEST_BIT 7
// File addresses with special behaviour
`define AALFO_FA_TIMER 7'h01
`define AALFO_FA_PORT 7'h06
// Oscillator periods per instruction cycle
`define AALFO_PHASES 4
`define AALFO_PH_LAST 2'h3
`endif

// ===== rtl/aalfo_pkg.sv
package aalfo_pkg;
  typedef enum logic [2:0] {
    AALFO_OP_NONE,
    AALFO_OP_ADD_LIT,
    AALFO_OP_AND_LIT,
    AALFO_OP_ADD_FILE,
    AALFO_OP_BRANCH
  } aalfo_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_IDLECYC} aalfo_state_t;
endpackage : aalfo_pkg

// ===== rtl/aalfo_alu.sv
`timescale 1ns/100ps
module aalfo_alu
  import aalfo_pkg::*;
(
  input wire aalfo_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  output logic [7:0] result,
  output logic carry,
  output logic digit,
  output logic zero,
  output logic upd_cdc
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  wire is_and = (op == AALFO_OP_AND_LIT);

  assign sum9 = {1'b0, acc} + {1'b0, opnd};
  assign sum5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
  assign result = is_and ? (acc & opnd) : sum9[7:0];
  // Logical op leaves carry and digit carry untouched
  assign upd_cdc = ~is_and;
  assign carry = sum9[8];
  assign digit = sum5[4];
  assign zero = (result == 8'h00);
endmodule : aalfo_alu

// ===== rtl/aalfo_core.sv
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "aalfo_defs.svh"
// Functional notes
// - Read-modify-write of the I/O port uses synchronised pin levels, not latch.
// - Result written to timer count with d=1 clears an assigned prescaler.
// - PC-changing or true-test instructions take two cycles, second idle.
// - Opcode 11 111x: acc plus literal into acc, update C, DC, Z.
// - Opcode 11 1001: acc AND literal into acc, only Z updated.
// - Add acc to file: acc plus 7-bit addressed file, update C, DC, Z.
// - Destination bit 0 writes acc only; 1 writes the file register.
// - One instruction cycle lasts four oscillator periods.
module aalfo_core
  import aalfo_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] daddr_ff;
  logic wr_ph_ff, rd_wait_ff, hready_ff;
  logic [31:0] hrdata_ff;
  logic [13:0] instr_ff;
  logic [7:0] acc_ff, timer_ff, presc_ff, port_ff;
  logic [6:0] faddr_ff;
  logic c_ff, dc_ff, z_ff, psa_ff;
  logic [1:0] phase_ff;
  aalfo_state_t st_ff, nxt_st;
  logic [7:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff;
  logic [7:0] fram [0:127];

  wire ap_valid = hsel & htrans[1] & hready;
  wire bus_wr = wr_ph_ff;
  wire wr_instr = bus_wr & (daddr_ff == `AALFO_OFS_INSTR);
  wire wr_acc = bus_wr & (daddr_ff == `AALFO_OFS_ACC);
  wire wr_flags = bus_wr & (daddr_ff == `AALFO_OFS_FLAGS);
  wire wr_ctrl = bus_wr & (daddr_ff == `AALFO_OFS_CTRL);
  wire wr_timer = bus_wr & (daddr_ff == `AALFO_OFS_TIMER);
  wire wr_faddr = bus_wr & (daddr_ff == `AALFO_OFS_FADDR);
  wire wr_fdata = bus_wr & (daddr_ff == `AALFO_OFS_FDATA);
  wire busy = (st_ff != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [5:0] opc = instr_ff[`AALFO_OPC_HI:`AALFO_OPC_LO];
  wire [6:0] f_addr = instr_ff[6:0];
  wire dest_file = instr_ff[`AALFO_DEST_BIT];
  wire [7:0] lit = instr_ff[7:0];
  aalfo_op_t op;
  assign op = (opc[5:1] == 5'h1F) ? AALFO_OP_ADD_LIT :
              (opc == 6'h39) ? AALFO_OP_AND_LIT :
              (opc == 6'h07) ? AALFO_OP_ADD_FILE :
              (opc[5:4] == 2'h2) ? AALFO_OP_BRANCH : AALFO_OP_NONE;
  wire is_file = (op == AALFO_OP_ADD_FILE);
  wire is_lit = (op == AALFO_OP_ADD_LIT) | (op == AALFO_OP_AND_LIT);
  wire exec_now = (st_ff == ST_EXEC) & (phase_ff == `AALFO_PH_LAST);
  wire cyc_end = (phase_ff == `AALFO_PH_LAST);

  // Every source is an argument so that callers in continuous assignments see each change
  function automatic logic [7:0] file_rd(input logic [6:0] a, input logic [7:0] pins,
                                         input logic [7:0] tmr, input logic [7:0] ram_word);
    if (a == `AALFO_FA_PORT) begin
      file_rd = pins;
    end else if (a == `AALFO_FA_TIMER) begin
      file_rd = tmr;
    end else begin
      file_rd = ram_word;
    end
  endfunction : file_rd

  wire [7:0] file_opnd = file_rd(f_addr, pin_lvl_ff, timer_ff, fram[f_addr]);
  wire [7:0] alu_opnd = is_file ? file_opnd : lit;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z, alu_upd;

  aalfo_alu u_alu (
    .op(op),
    .acc(acc_ff),
    .opnd(alu_opnd),
    .result(alu_res),
    .carry(alu_c),
    .digit(alu_dc),
    .zero(alu_z),
    .upd_cdc(alu_upd)
  );

  wire do_arith = exec_now & (is_lit | is_file);
  wire to_acc = do_arith & (is_lit | ~dest_file);
  wire to_file = exec_now & is_file & dest_file;
  wire file_wr_timer = to_file & (f_addr == `AALFO_FA_TIMER);
  wire file_wr_port = to_file & (f_addr == `AALFO_FA_PORT);
  wire file_wr_ram = to_file & ~file_wr_timer & ~file_wr_port;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: EXEC always spans a whole four-phase cycle
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (wr_instr) nxt_st = ST_FETCH;
      ST_FETCH: if (cyc_end) nxt_st = ST_EXEC;
      ST_EXEC: if (cyc_end) begin
        nxt_st = (op == AALFO_OP_BRANCH) ? ST_IDLECYC : ST_IDLE;
      end
      ST_IDLECYC: if (cyc_end) nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ST_IDLE;
      phase_ff <= 2'h0;
      instr_ff <= 14'h0000;
    end else begin
      st_ff <= nxt_st;
      phase_ff <= phase_ff + 2'h1;
      // New instruction ignored while one is in flight
      if (wr_instr & ~busy) instr_ff <= hwdata[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags; execution wins over a bus write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 8'h00;
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
    end else begin
      if (to_acc) acc_ff <= alu_res;
      else if (wr_acc) acc_ff <= hwdata[7:0];
      if (do_arith) begin
        z_ff <= alu_z;
        if (alu_upd) c_ff <= alu_c;
        if (alu_upd) dc_ff <= alu_dc;
      end else if (wr_flags) begin
        c_ff <= hwdata[`AALFO_FLG_CARRY];
        dc_ff <= hwdata[`AALFO_FLG_DIGIT];
        z_ff <= hwdata[`AALFO_FLG_ZERO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File registers, port latch, timer and prescaler
  wire bus_fd_ram = wr_fdata & (faddr_ff != `AALFO_FA_TIMER) & (faddr_ff != `AALFO_FA_PORT);

  always_ff @(posedge hclk) begin
    if (file_wr_ram) fram[f_addr] <= alu_res;
    else if (bus_fd_ram) fram[faddr_ff] <= hwdata[7:0];
  end

  wire presc_wrap = (presc_ff == 8'hFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_ff <= 8'h00;
      presc_ff <= 8'h00;
      psa_ff <= 1'b0;
      port_ff <= 8'h00;
      faddr_ff <= 7'h00;
    end else begin
      if (wr_ctrl) psa_ff <= hwdata[`AALFO_CTRL_PSA];
      if (wr_faddr) faddr_ff <= hwdata[6:0];
      if (file_wr_port) port_ff <= alu_res;
      else if (wr_fdata & (faddr_ff == `AALFO_FA_PORT)) port_ff <= hwdata[7:0];
      if (file_wr_timer) begin
        timer_ff <= alu_res;
        if (psa_ff) presc_ff <= 8'h00;
      end else if (wr_timer | (wr_fdata & (faddr_ff == `AALFO_FA_TIMER))) begin
        timer_ff <= hwdata[7:0];
      end else if (cyc_end) begin
        if (psa_ff) presc_ff <= presc_ff + 8'h01;
        if (~psa_ff | presc_wrap) timer_ff <= timer_ff + 8'h01;
      end
    end
  end

  // Three-stage pin sampling; level moves only when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
      pin_s3_ff <= 8'h00;
      pin_lvl_ff <= 8'h00;
    end else begin
      pin_s1_ff <= port_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      for (int i = 0; i < 8; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) pin_lvl_ff[i] <= pin_s3_ff[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero-wait, reads take one wait state
  logic [31:0] rmux;
  wire [7:0] fdata_rd = file_rd(faddr_ff, pin_lvl_ff, timer_ff, fram[faddr_ff]);
  assign rmux = (daddr_ff == `AALFO_OFS_INSTR) ? {18'h00000, instr_ff} :
                (daddr_ff == `AALFO_OFS_ACC) ? {24'h000000, acc_ff} :
                (daddr_ff == `AALFO_OFS_FLAGS) ?
                  {23'h000000, busy, 5'h00, z_ff, dc_ff, c_ff} :
                (daddr_ff == `AALFO_OFS_CTRL) ? {31'h00000000, psa_ff} :
                (daddr_ff == `AALFO_OFS_TIMER) ? {16'h0000, presc_ff, timer_ff} :
                (daddr_ff == `AALFO_OFS_FADDR) ? {25'h0000000, faddr_ff} :
                (daddr_ff == `AALFO_OFS_FDATA) ? {24'h000000, fdata_rd} :
                32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      daddr_ff <= 8'h00;
      wr_ph_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
    end else begin
      if (ap_valid) daddr_ff <= {haddr[7:2], 2'h0};
      wr_ph_ff <= ap_valid & hwrite;
      rd_wait_ff <= ap_valid & ~hwrite;
      hready_ff <= ~(ap_valid & ~hwrite);
      if (rd_wait_ff) hrdata_ff <= rmux;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0 & hready_ff;
  assign port_out = port_ff;

  ////////////////////////////////////////////////////////////////////////////
  chk_pin_operand: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & is_file & (f_addr == `AALFO_FA_PORT) |-> alu_opnd == pin_lvl_ff)
    else $error("port operand not taken from pins");
  chk_presc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    file_wr_timer & psa_ff |=> presc_ff == 8'h00)
    else $error("prescaler not cleared");
  chk_branch_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & (op == AALFO_OP_BRANCH) |=> (st_ff == ST_IDLECYC)[*4] ##1 st_ff == ST_IDLE)
    else $error("branch second cycle wrong");
  chk_add_lit: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & (op == AALFO_OP_ADD_LIT) |=>
      acc_ff == 8'($past(acc_ff) + $past(lit)) && c_ff == ($past({1'b0, acc_ff} + {1'b0, lit}) > 9'h0FF))
    else $error("add literal wrong");
  chk_and_lit: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & (op == AALFO_OP_AND_LIT) |=>
      acc_ff == ($past(acc_ff) & $past(lit)) && $stable(c_ff) && $stable(dc_ff))
    else $error("and literal wrong");
  chk_add_file_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & is_file |=> z_ff == ($past(alu_res) == 8'h00) && dc_ff == $past(alu_dc))
    else $error("add file flags wrong");
  chk_dest_select: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & is_file & dest_file & ~wr_acc |=> $stable(acc_ff))
    else $error("acc changed for file destination");
  chk_cycle_four: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff == ST_EXEC) |-> (st_ff == ST_EXEC)[*4] ##1 st_ff != ST_EXEC)
    else $error("instruction cycle not four periods");
  chk_single_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
    exec_now & (is_lit | is_file) |=> st_ff == ST_IDLE)
    else $error("covered instruction not single cycle");
  cov_add_file_mem: cover property (@(posedge hclk) disable iff (!hresetn) file_wr_ram);
  cov_port_rmw: cover property (@(posedge hclk) disable iff (!hresetn) file_wr_port);
  cov_branch: cover property (@(posedge hclk) disable iff (!hresetn)
    exec_now & (op == AALFO_OP_BRANCH));
endmodule : aalfo_core

// ===== bench/add_and_literal_file_ops_bench.sv
`timescale 1ns/100ps
`include "aalfo_defs.svh"
module add_and_literal_file_ops_bench
  import aalfo_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdy_s;
  logic [31:0] haddr, hwdata, hrdata, rd_s, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] port_pins, port_out, t1;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, dur;
  assign hready = hreadyout;
  aalfo_core i_aalfo_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_pins(port_pins),
    .port_out(port_out));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Registered outputs are copied mid-cycle so the rising edge reads them race free
  always @(negedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (rdy_s !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (rdy_s !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t bus hang", $time);
      final_report;
    end
  endtask : wait_rdy
  // One single word transfer; the address phase is held until hready is seen high
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = rd_s;
  endtask : xfer
  task rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    xfer(1'b0, a, 32'h0);
    check(rv, exp, msg);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // Busy is polled; the bound keeps a stuck core from hanging the run
  task exec(input logic [13:0] op);
    int n;
    n = 0;
    wr(`AALFO_OFS_INSTR, {18'h0, op});
    t0 = cyc;
    rv = 32'h100;
    while (rv[`AALFO_FLG_BUSY] !== 1'b0 && n < 20) begin
      xfer(1'b0, `AALFO_OFS_FLAGS, 32'h0);
      n++;
    end
    if (rv[`AALFO_FLG_BUSY] !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t busy stuck", $time);
      final_report;
    end
    dur = cyc - t0;
  endtask : exec
  task lit(input logic [13:0] op, input logic [7:0] a, input logic [7:0] r,
           input logic [2:0] f);
    wr(`AALFO_OFS_ACC, {24'h0, a});
    exec(op);
    rd(`AALFO_OFS_ACC, {24'h0, r}, "acc");
    rd(`AALFO_OFS_FLAGS, {29'h0, f}, "flags");
  endtask : lit
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`AALFO_OFS_ACC, 32'h0, "acc rst");
    rd(`AALFO_OFS_FLAGS, 32'h0, "flags rst");
    rd(`AALFO_OFS_CTRL, 32'h0, "ctrl rst");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, "unmapped");
  endtask : t_reset
  task t_add_lit;
    lit(14'h3E15, 8'h10, 8'h25, 3'b000);
    lit(14'h3F01, 8'hFF, 8'h00, 3'b111);
    lit(14'h3E08, 8'h08, 8'h10, 3'b010);
  endtask : t_add_lit
  task t_and_lit;
    // Carry and digit carry are preset to show that only zero moves
    wr(`AALFO_OFS_FLAGS, 32'h3);
    lit(14'h395F, 8'hA3, 8'h03, 3'b011);
    lit(14'h395C, 8'hA3, 8'h00, 3'b111);
  endtask : t_and_lit
  task t_add_file;
    wr(`AALFO_OFS_FADDR, 32'h20);
    wr(`AALFO_OFS_FDATA, 32'hC2);
    lit(14'h0720, 8'h17, 8'hD9, 3'b000);
    rd(`AALFO_OFS_FDATA, 32'hC2, "file kept");
    lit(14'h07A0, 8'hD9, 8'hD9, 3'b001);
    rd(`AALFO_OFS_FDATA, 32'h9B, "file sum");
    wr(`AALFO_OFS_FADDR, 32'h7F);
    wr(`AALFO_OFS_FDATA, 32'h01);
    lit(14'h07FF, 8'hFF, 8'hFF, 3'b111);
    rd(`AALFO_OFS_FDATA, 32'h00, "file top");
  endtask : t_add_file
  task t_port;
    port_pins <= 8'h0F;
    wr(`AALFO_OFS_FADDR, {25'h0, `AALFO_FA_PORT});
    wr(`AALFO_OFS_FDATA, 32'hFF);
    // The latch loads at the edge the write ends on; look once it has settled
    @(negedge hclk);
    check({24'h0, port_out}, 32'hFF, "latch");
    lit(14'h0786, 8'h00, 8'h00, 3'b000);
    check({24'h0, port_out}, 32'h0F, "pins");
  endtask : t_port
  task t_rate;
    // Read addresses land exactly 40 clocks apart, ten instruction cycles
    xfer(1'b0, `AALFO_OFS_TIMER, 32'h0);
    t1 = rv[7:0];
    repeat (36) @(posedge hclk);
    xfer(1'b0, `AALFO_OFS_TIMER, 32'h0);
    check({24'h0, rv[7:0] - t1}, 32'd10, "timer rate");
  endtask : t_rate
  task t_presc;
    wr(`AALFO_OFS_CTRL, 32'h1);
    repeat (60) @(posedge hclk);
    xfer(1'b0, `AALFO_OFS_TIMER, 32'h0);
    check({31'h0, rv[15:8] > 8'h8}, 32'h1, "presc runs");
    wr(`AALFO_OFS_ACC, 32'h0);
    exec(14'h0781);
    xfer(1'b0, `AALFO_OFS_TIMER, 32'h0);
    check({31'h0, rv[15:8] < 8'h4}, 32'h1, "presc clr");
    wr(`AALFO_OFS_CTRL, 32'h0);
  endtask : t_presc
  task t_timing;
    int dur_b;
    wr(`AALFO_OFS_ACC, 32'h55);
    exec(14'h2800);
    dur_b = dur;
    check({31'h0, dur >= 12}, 32'h1, "branch long");
    rd(`AALFO_OFS_ACC, 32'h55, "idle no effect");
    // One spare clock puts the second start on the same phase, so only the idle cycle differs
    @(posedge hclk);
    exec(14'h3E00);
    check({31'h0, dur <= 13}, 32'h1, "one cycle");
    check(dur, dur_b - `AALFO_PHASES, "idle cycle length");
  endtask : t_timing
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    port_pins = 8'h00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_add_lit;
    t_and_lit;
    t_add_file;
    t_port;
    t_rate;
    t_presc;
    t_timing;
    final_report;
  end
endmodule : add_and_literal_file_ops_bench
